// [rtl/csp_regs.svh]
// Register offsets, field positions, reset values and timing counts of the card-slot port.
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

`define CSP_REG_REVISION     3'h0
`define CSP_REG_MISC         3'h1
`define CSP_REG_PIN12_CTRL   3'h2
`define CSP_REG_STRAP_STAT   3'h3
`define CSP_REG_COUNT        8
`define CSP_MISC_RST         8'h80
`define CSP_MISC_LOCK_BIT    7
`define CSP_MISC_CAM_PWR_BIT 0
`define CSP_PIN12_DATA_BIT   0
`define CSP_PIN12_OE_BIT     1
`define CSP_MODE_CARD        4'h8
`define CSP_ADDR_BUF_BIT     23
`define CSP_BUF_DEPTH        16
`define CSP_REFRESH_PERIOD   4'hf
`define CSP_REFRESH_LEN      4'h3
`define CSP_ALE_CYC          4'h4
`define CSP_STRB_MIN         4'h8
`define CSP_RECOVER_CYC      4'h5
`define CSP_BCLK_HALF        2'h1

`endif

// [rtl/csp_pkg.sv]
// Types shared by both ends of the card-slot port.
package csp_pkg;
    typedef enum logic [1:0] {DEV_IDLE, DEV_ARB, DEV_DONE} csp_dev_state_t;
    typedef enum logic [2:0] {HST_IDLE, HST_ALE, HST_ALE_LO, HST_STRB, HST_WAIT,
                              HST_END} csp_hst_state_t;
endpackage

// [rtl/csp_if.sv]
// Pin-level carrier between the slot controller and the display controller port.
`timescale 1ns/1ps
interface csp_if;
    logic        addr_latch_strobe_in;
    logic        card_reg_space_in;
    logic        io_read_strobe_in;
    logic        io_write_strobe_in;
    logic [3:0]  unused_upper_address;
    logic [12:0] low_address_bus;
    logic        high_byte_strobe;
    logic        low_byte_strobe;
    logic        mem_read_strobe;
    logic        mem_write_strobe;
    logic        mem_reg_sel_in;
    logic        chip_sel_in;
    logic        bus_start_in;
    logic        host_bus_clock;
    logic [15:0] host_out_data;
    logic        host_data_oe_n;
    logic [15:0] dev_out_data;
    logic        dev_data_oe_n;
    logic        hold_off_out_n;
    logic        hold_off_oe_n;
    logic [15:0] host_data_bus;
    logic        hold_off_n;

    // Wire levels: a driver with its enable low wins, an undriven line floats high.
    assign host_data_bus = !dev_data_oe_n ? dev_out_data :
                           (!host_data_oe_n ? host_out_data : 16'hffff);
    assign hold_off_n    = !hold_off_oe_n ? hold_off_out_n : 1'b1;

    modport device (
        input  addr_latch_strobe_in, card_reg_space_in, io_read_strobe_in,
        input  io_write_strobe_in, unused_upper_address, low_address_bus,
        input  high_byte_strobe, low_byte_strobe, mem_read_strobe, mem_write_strobe,
        input  mem_reg_sel_in, chip_sel_in, bus_start_in, host_bus_clock, host_data_bus,
        output dev_out_data, dev_data_oe_n, hold_off_out_n, hold_off_oe_n
    );
    modport host (
        output addr_latch_strobe_in, card_reg_space_in, io_read_strobe_in,
        output io_write_strobe_in, unused_upper_address, low_address_bus,
        output high_byte_strobe, low_byte_strobe, mem_read_strobe, mem_write_strobe,
        output mem_reg_sel_in, chip_sel_in, bus_start_in, host_bus_clock,
        output host_out_data, host_data_oe_n,
        input  host_data_bus, hold_off_n
    );
endinterface

// [rtl/csp_device.sv]
// Display controller end of the card-slot host bus port.
// Contract
// - Sample mode straps at reset release; 1000 selects port.
// - Pins keep strapped function until next reset.
// - Lock bit resets 1; only 000h/001h respond; the buffer half still answers while locked.
// - Sixteen-bit data path for registers and buffer.
// - Latch upper address on strobe falling edge.
// - Host asserts card register space on access.
// - Either read strobe starts a read.
// - Either write strobe starts a write.
// - Host ties unused address and selects high.
// - Little endian lanes: high byte to D23:16.
// - Two host selects steer the byte lanes.
// - Hold-off until data valid or accepted.
// - Strap chooses hold-off always driven or tristated.
// - Strap halves the host bus clock.
// - Control inputs synchronised, taken asynchronously.
// - Host bus clock separate from core clock.
// - Reserved strap tied to ground.
// - Camera strap turns pin twelve into power enable.
// - Attribute and IO space answer identically.
// - Registers low half, buffer high half, aliased.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_device
    import csp_pkg::*;
#(
    parameter logic [7:0] REV_CODE = 8'h5a  // Arbitrary value.
) (
    input  wire logic clock,
    input  wire logic rst,
    csp_if.device     bus,
    input  wire logic [3:0] bus_mode_straps,
    input  wire logic reserved_strap,
    input  wire logic clock_divide_strap,
    input  wire logic hold_off_drive_strap,
    input  wire logic camera_feature_strap,
    input  wire logic general_pin_twelve_in,
    output logic      general_pin_twelve_out_ff,
    output logic      general_pin_twelve_oe_n_ff,
    output logic      port_enabled_ff
);
    // Synchroniser bit positions.
    localparam int S_ALE = 0;
    localparam int S_REG = 1;
    localparam int S_IRD = 2;
    localparam int S_IWR = 3;
    localparam int S_MRD = 4;
    localparam int S_MWR = 5;
    localparam int S_HI  = 6;
    localparam int S_LO  = 7;
    localparam int S_CLK = 8;

    csp_dev_state_t state_ff, nxt_state;
    logic [8:0]  sync1_ff, sync2_ff, sync3_ff;
    logic [8:0]  raw_ctl;
    logic        straps_taken_ff;
    logic [7:0]  strap_ff;
    logic [10:0] upper_ff;
    logic [3:0]  refresh_cnt_ff;
    logic        div_ff;
    logic [7:0]  regs_ff [`CSP_REG_COUNT];
    logic [15:0] buf_ff [`CSP_BUF_DEPTH];
    logic [15:0] rdata_ff, nxt_rdata;
    logic        data_oe_n_ff, nxt_data_oe_n;
    logic        hold_off_ff, nxt_hold_off;
    logic        hold_oe_n_ff, nxt_hold_oe_n;

    // Strap-derived mode, fixed from the first edge after reset release.
    wire mode_ok     = straps_taken_ff && strap_ff[3:0] == `CSP_MODE_CARD;
    wire div_en      = strap_ff[5];
    wire hold_always = strap_ff[6];
    wire cam_en      = strap_ff[7];

    // Decoded bus view, from the second synchroniser stage; the edge detects also use the third.
    wire sel      = !sync2_ff[S_REG];
    wire rd       = !sync2_ff[S_IRD] || !sync2_ff[S_MRD];
    wire wr       = !sync2_ff[S_IWR] || !sync2_ff[S_MWR];
    wire lane_hi  = !sync2_ff[S_HI];
    wire lane_lo  = !sync2_ff[S_LO];
    wire access   = mode_ok && sel && (rd || wr);
    wire ale_fall = sync3_ff[S_ALE] && !sync2_ff[S_ALE];
    wire clk_rise = sync2_ff[S_CLK] && !sync3_ff[S_CLK];
    wire bus_tick = clk_rise && (!div_en || div_ff);
    wire refresh_busy = refresh_cnt_ff < `CSP_REFRESH_LEN;
    wire grant    = bus_tick && !refresh_busy;

    // Address decode; registers ignore bits 22:21, so their image repeats four times; the buffer ignores bits 22:5.
    wire [23:0] full_addr = {upper_ff, bus.low_address_bus};
    wire        is_buf    = full_addr[`CSP_ADDR_BUF_BIT];
    wire [1:0]  reg_word  = full_addr[2:1];
    wire        reg_in    = full_addr[20:3] == 18'h00000;
    wire        locked    = regs_ff[`CSP_REG_MISC][`CSP_MISC_LOCK_BIT];
    wire        reg_ok    = reg_in && (!locked || reg_word == 2'h0);
    wire [3:0]  buf_idx   = full_addr[4:1];
    wire [2:0]  byte_lo   = {reg_word, 1'b0};
    wire [2:0]  byte_hi   = {reg_word, 1'b1};

    // Register read view: revision and strap status are read-only.
    function automatic logic [7:0] reg_view(input logic [2:0] idx);
        logic [7:0] val;
        val = regs_ff[idx];
        if (idx == `CSP_REG_REVISION) begin
            val = REV_CODE;
        end else if (idx == `CSP_REG_STRAP_STAT) begin
            val = strap_ff;
        end
        return val;
    endfunction

    wire [15:0] reg_word_rd = reg_ok ? {reg_view(byte_hi), reg_view(byte_lo)} : 16'h0000;
    wire [15:0] rd_word     = is_buf ? buf_ff[buf_idx] : reg_word_rd;
    wire        do_write    = state_ff == DEV_ARB && grant && wr;

    // Two-stage synchronisers plus a third stage for edge detection.
    assign raw_ctl = {bus.host_bus_clock, bus.low_byte_strobe, bus.high_byte_strobe,
                      bus.mem_write_strobe, bus.mem_read_strobe, bus.io_write_strobe_in,
                      bus.io_read_strobe_in, bus.card_reg_space_in,
                      bus.addr_latch_strobe_in};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_ff <= 9'h1fe;
            sync2_ff <= 9'h1fe;
            sync3_ff <= 9'h1fe;
        end else begin
            sync1_ff <= raw_ctl;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Straps are caught once, on the first edge after reset release.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            straps_taken_ff <= 1'b0;
            strap_ff        <= 8'h00;
        end else if (!straps_taken_ff) begin
            straps_taken_ff <= 1'b1;
            strap_ff <= {camera_feature_strap, hold_off_drive_strap, clock_divide_strap,
                         reserved_strap, bus_mode_straps};
        end
    end

    // Upper address latch, refresh arbiter counter and bus clock divider.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upper_ff       <= 11'h000;
            refresh_cnt_ff <= 4'h0;
            div_ff         <= 1'b0;
        end else begin
            if (mode_ok && ale_fall) begin
                upper_ff <= bus.low_address_bus[10:0];
            end
            refresh_cnt_ff <= refresh_cnt_ff == `CSP_REFRESH_PERIOD ? 4'h0 :
                              refresh_cnt_ff + 4'h1;
            if (clk_rise) begin
                div_ff <= !div_ff;
            end
        end
    end

    // Register bytes, written lane by lane; read-only bytes are stored on write too but never read back.
    for (genvar i = 0; i < `CSP_REG_COUNT; i++) begin : g_reg
        localparam logic [2:0] IDX = 3'(i);
        localparam logic [7:0] RST = (i == 1) ? `CSP_MISC_RST : 8'h00;
        wire wr_lo = !is_buf && reg_ok && lane_lo && byte_lo == IDX;
        wire wr_hi = !is_buf && reg_ok && lane_hi && byte_hi == IDX;
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                regs_ff[i] <= RST;
            end else if (do_write && wr_lo) begin
                regs_ff[i] <= bus.host_data_bus[7:0];
            end else if (do_write && wr_hi) begin
                regs_ff[i] <= bus.host_data_bus[15:8];
            end
        end
    end

    // Display buffer words with byte lane enables.
    for (genvar j = 0; j < `CSP_BUF_DEPTH; j++) begin : g_buf
        wire hit = do_write && is_buf && buf_idx == 4'(j);
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                buf_ff[j] <= 16'h0000;
            end else if (hit) begin
                buf_ff[j] <= {lane_hi ? bus.host_data_bus[15:8] : buf_ff[j][15:8],
                              lane_lo ? bus.host_data_bus[7:0] : buf_ff[j][7:0]};
            end
        end
    end

    // Access sequencer: hold off, wait for a grant, then present or accept data.
    always_comb begin
        nxt_state     = state_ff;
        nxt_rdata     = rdata_ff;
        nxt_data_oe_n = data_oe_n_ff;
        nxt_hold_off  = hold_off_ff;
        case (state_ff)
            DEV_IDLE: begin
                nxt_data_oe_n = 1'b1;
                if (access) begin
                    nxt_state    = DEV_ARB;
                    nxt_hold_off = 1'b0;
                end
            end
            DEV_ARB: begin
                if (!access) begin
                    nxt_state    = DEV_IDLE;
                    nxt_hold_off = 1'b1;
                end else if (grant) begin
                    nxt_state     = DEV_DONE;
                    nxt_hold_off  = 1'b1;
                    nxt_rdata     = rd_word;
                    nxt_data_oe_n = !rd;
                end
            end
            DEV_DONE: begin
                if (!access) begin
                    nxt_state     = DEV_IDLE;
                    nxt_data_oe_n = 1'b1;
                end
            end
            default: begin
                nxt_state     = DEV_IDLE;
                nxt_data_oe_n = 1'b1;
                nxt_hold_off  = 1'b1;
            end
        endcase
        nxt_hold_oe_n = !(mode_ok && (hold_always || access));
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff     <= DEV_IDLE;
            rdata_ff     <= 16'h0000;
            data_oe_n_ff <= 1'b1;
            hold_off_ff  <= 1'b1;
            hold_oe_n_ff <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            rdata_ff     <= nxt_rdata;
            data_oe_n_ff <= nxt_data_oe_n;
            hold_off_ff  <= nxt_hold_off;
            hold_oe_n_ff <= nxt_hold_oe_n;
        end
    end

    assign bus.dev_out_data   = rdata_ff;
    assign bus.dev_data_oe_n  = data_oe_n_ff;
    assign bus.hold_off_out_n = hold_off_ff;
    assign bus.hold_off_oe_n  = hold_oe_n_ff;

    // Pin twelve: camera power enable or plain general-purpose output.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            general_pin_twelve_out_ff  <= 1'b0;
            general_pin_twelve_oe_n_ff <= 1'b1;
            port_enabled_ff            <= 1'b0;
        end else begin
            port_enabled_ff <= mode_ok;
            if (cam_en) begin
                general_pin_twelve_out_ff  <= regs_ff[`CSP_REG_MISC][`CSP_MISC_CAM_PWR_BIT];
                general_pin_twelve_oe_n_ff <= 1'b0;
            end else begin
                general_pin_twelve_out_ff  <= regs_ff[`CSP_REG_PIN12_CTRL][`CSP_PIN12_DATA_BIT];
                general_pin_twelve_oe_n_ff <= !regs_ff[`CSP_REG_PIN12_CTRL][`CSP_PIN12_OE_BIT];
            end
        end
    end

    // The pin twelve input is not read back by this port; it is kept only for pin parity.
    wire unused_pin_in = general_pin_twelve_in;
endmodule // csp_device

// [rtl/csp_host.sv]
// Slot controller end of the card-slot host bus port.
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_host
    import csp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    csp_if.host              bus,
    input  wire logic        req,
    input  wire logic        req_we,
    input  wire logic        req_io,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic [1:0]  req_be,
    output logic             busy_ff,
    output logic             done_ff,
    output logic [15:0]      rdata_ff
);
    csp_hst_state_t state_ff;
    logic [3:0]  cnt_ff;
    logic [23:0] addr_ff;
    logic        we_ff, io_ff;
    logic [1:0]  be_ff;
    logic [31:16] d_out_ff;
    logic        d_oe_n_ff, ale_ff, reg_n_ff;
    logic        io_rd_n_ff, io_wr_n_ff, mem_rd_n_ff, mem_wr_n_ff, hi_n_ff, lo_n_ff;
    logic [12:0] addr_out_ff;
    logic [1:0]  bclk_cnt_ff;
    logic        bclk_ff, wait1_ff, wait2_ff;

    // Host bus lanes: low byte travels on D31:24, high byte on D23:16.
    wire [31:16] d_in = {bus.host_data_bus[7:0], bus.host_data_bus[15:8]};

    assign bus.addr_latch_strobe_in = ale_ff;
    assign bus.card_reg_space_in    = reg_n_ff;
    assign bus.io_read_strobe_in    = io_rd_n_ff;
    assign bus.io_write_strobe_in   = io_wr_n_ff;
    assign bus.mem_read_strobe      = mem_rd_n_ff;
    assign bus.mem_write_strobe     = mem_wr_n_ff;
    assign bus.high_byte_strobe     = hi_n_ff;
    assign bus.low_byte_strobe      = lo_n_ff;
    assign bus.low_address_bus      = addr_out_ff;
    assign bus.host_out_data        = {d_out_ff[23:16], d_out_ff[31:24]};
    assign bus.host_data_oe_n       = d_oe_n_ff;
    assign bus.host_bus_clock       = bclk_ff;
    assign bus.unused_upper_address = 4'hf;
    assign bus.mem_reg_sel_in       = 1'b1;
    assign bus.chip_sel_in          = 1'b1;
    assign bus.bus_start_in         = 1'b1;

    // Bus clock divider and hold-off synchroniser.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bclk_cnt_ff <= 2'h0;
            bclk_ff     <= 1'b0;
            wait1_ff    <= 1'b1;
            wait2_ff    <= 1'b1;
        end else begin
            bclk_cnt_ff <= bclk_cnt_ff == `CSP_BCLK_HALF ? 2'h0 : bclk_cnt_ff + 2'h1;
            bclk_ff     <= bclk_cnt_ff == `CSP_BCLK_HALF ? !bclk_ff : bclk_ff;
            wait1_ff    <= bus.hold_off_n;
            wait2_ff    <= wait1_ff;
        end
    end

    // Cycle sequencer: latch phase, strobe phase, hold-off wait, recovery.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= HST_IDLE;
            cnt_ff <= 4'h0;
            addr_ff <= 24'h000000;
            we_ff <= 1'b0;
            io_ff <= 1'b0;
            be_ff <= 2'h0;
            d_out_ff <= 16'h0000;
            d_oe_n_ff <= 1'b1;
            ale_ff <= 1'b0;
            reg_n_ff <= 1'b1;
            io_rd_n_ff <= 1'b1;
            io_wr_n_ff <= 1'b1;
            mem_rd_n_ff <= 1'b1;
            mem_wr_n_ff <= 1'b1;
            hi_n_ff <= 1'b1;
            lo_n_ff <= 1'b1;
            addr_out_ff <= 13'h0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                HST_IDLE: begin
                    if (req) begin
                        addr_ff <= req_addr;
                        we_ff <= req_we;
                        io_ff <= req_io;
                        be_ff <= req_be;
                        d_out_ff <= {req_wdata[7:0], req_wdata[15:8]};
                        addr_out_ff <= {2'h0, req_addr[23:13]};
                        ale_ff <= 1'b1;
                        reg_n_ff <= 1'b0;
                        busy_ff <= 1'b1;
                        cnt_ff <= `CSP_ALE_CYC;
                        state_ff <= HST_ALE;
                    end
                end
                HST_ALE: begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        ale_ff <= 1'b0;
                        cnt_ff <= `CSP_ALE_CYC;
                        state_ff <= HST_ALE_LO;
                    end
                end
                HST_ALE_LO: begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        addr_out_ff <= addr_ff[12:0];
                        hi_n_ff <= !be_ff[1];
                        lo_n_ff <= !be_ff[0];
                        d_oe_n_ff <= !we_ff;
                        io_rd_n_ff <= !(io_ff && !we_ff);
                        io_wr_n_ff <= !(io_ff && we_ff);
                        mem_rd_n_ff <= !(!io_ff && !we_ff);
                        mem_wr_n_ff <= !(!io_ff && we_ff);
                        cnt_ff <= `CSP_STRB_MIN;
                        state_ff <= HST_STRB;
                    end
                end
                HST_STRB: begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        state_ff <= HST_WAIT;
                    end
                end
                HST_WAIT: begin
                    if (wait2_ff) begin
                        rdata_ff <= {d_in[23:16], d_in[31:24]};
                        io_rd_n_ff <= 1'b1;
                        io_wr_n_ff <= 1'b1;
                        mem_rd_n_ff <= 1'b1;
                        mem_wr_n_ff <= 1'b1;
                        hi_n_ff <= 1'b1;
                        lo_n_ff <= 1'b1;
                        reg_n_ff <= 1'b1;
                        d_oe_n_ff <= 1'b1;
                        cnt_ff <= `CSP_RECOVER_CYC;
                        state_ff <= HST_END;
                    end
                end
                HST_END: begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= HST_IDLE;
                    end
                end
                default: begin
                    state_ff <= HST_IDLE;
                end
            endcase
        end
    end
endmodule // csp_host

// [tb/csp_props.sv]
// Pin-level checks on the carrier between the slot controller and the port.
`timescale 1ns/1ps
module csp_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       addr_latch_strobe_in,
    input wire logic       io_read_strobe_in,
    input wire logic       io_write_strobe_in,
    input wire logic       mem_read_strobe,
    input wire logic       mem_write_strobe,
    input wire logic [3:0] unused_upper_address,
    input wire logic       bus_start_in,
    input wire logic       dev_data_oe_n,
    input wire logic       hold_off_n
);
    // Any read or any write strobe of either space.
    wire rd_on = !io_read_strobe_in || !mem_read_strobe;
    wire wr_on = !io_write_strobe_in || !mem_write_strobe;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence quiet4; (!rd_on && !wr_on) [*4]; endsequence
    sequence held_off; !hold_off_n && (rd_on || wr_on); endsequence
    a_read_drive: assert property ($fell(dev_data_oe_n) |-> rd_on)
        else $error("data driven outside a read");
    a_write_quiet: assert property (!dev_data_oe_n |-> !wr_on)
        else $error("data driven during a write");
    a_drive_gone: assert property (quiet4 |-> dev_data_oe_n)
        else $error("data still driven when idle");
    a_ties_high: assert property (unused_upper_address == 4'hf && bus_start_in)
        else $error("unused inputs not high");
    a_holdoff_bounded: assert property ($fell(hold_off_n) |-> ##[1:60] hold_off_n)
        else $error("hold-off never ended");
    a_host_extends: assert property (held_off |=> (rd_on || wr_on))
        else $error("host ended cycle during hold-off");
    a_holdoff_idle: assert property (quiet4 |-> hold_off_n)
        else $error("hold-off active while idle");
    a_ale_idle: assert property (addr_latch_strobe_in |-> !rd_on && !wr_on)
        else $error("strobe during address phase");
endmodule // csp_props

// [tb/card_slot_host_bus_port_test.sv]
// Self-checking bench joining both ends of the card-slot port.
`timescale 1ns/1ps
module card_slot_host_bus_port_test;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
    logic        clock = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, io = 1'b0;
    logic        div = 1'b0, drv = 1'b0, cam = 1'b0, busy_ff, done_ff, pen, p12oe, p12out;
    logic [23:0] addr = 24'h0;
    logic [15:0] wdata = 16'h0, rdata_ff;
    logic [1:0]  be = 2'h0;
    logic [3:0]  straps = 4'h8;
    int          bad_count = 0, tests_run = 0;
    csp_if i_csp_if ();
    csp_device i_csp_device (.clock(clock), .rst(rst), .bus(i_csp_if),
        .bus_mode_straps(straps), .reserved_strap(1'b0), .clock_divide_strap(div),
        .hold_off_drive_strap(drv), .camera_feature_strap(cam), .general_pin_twelve_in(1'b0),
        .general_pin_twelve_out_ff(p12out), .general_pin_twelve_oe_n_ff(p12oe),
        .port_enabled_ff(pen));
    csp_host i_csp_host (.clock(clock), .rst(rst), .bus(i_csp_if), .req(req), .req_we(we),
        .req_io(io), .req_addr(addr), .req_wdata(wdata), .req_be(be), .busy_ff(busy_ff),
        .done_ff(done_ff), .rdata_ff(rdata_ff));
    csp_props i_csp_props (.clock(clock), .rst(rst),
        .addr_latch_strobe_in(i_csp_if.addr_latch_strobe_in),
        .io_read_strobe_in(i_csp_if.io_read_strobe_in),
        .io_write_strobe_in(i_csp_if.io_write_strobe_in),
        .mem_read_strobe(i_csp_if.mem_read_strobe), .mem_write_strobe(i_csp_if.mem_write_strobe),
        .unused_upper_address(i_csp_if.unused_upper_address),
        .bus_start_in(i_csp_if.bus_start_in), .dev_data_oe_n(i_csp_if.dev_data_oe_n),
        .hold_off_n(i_csp_if.hold_off_n));
    // The 200 MHz clock.
    initial forever #2.5 clock = ~clock;
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Resets for 20 cycles with the given straps, which stay put afterwards.
    task rst_go(input logic [3:0] s, input logic d, input logic h, input logic c);
        @(posedge clock);
        rst <= 1'b1; straps <= s; div <= d; drv <= h; cam <= c;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    // One command to the slot controller, waiting a bounded time for done.
    task xfer(input logic w, input logic i, input logic [23:0] a, input logic [15:0] d,
              input logic [1:0] b);
        int n;
        @(posedge clock);
        req <= 1'b1; we <= w; io <= i; addr <= a; wdata <= d; be <= b;
        @(posedge clock);
        req <= 1'b0;
        n = 0;
        while (done_ff !== 1'b1 && n < 300) begin @(posedge clock); #1; n++; end
        if (n >= 300) begin bad_count++; end_sim(); end
    endtask
    task rd(input logic i, input logic [23:0] a, input logic [15:0] e);
        xfer(1'b0, i, a, 16'h0, 2'h3);
        `CHK("rdata", e, rdata_ff)
    endtask
    task t_lock;
        rd(1'b1, 24'h0, 16'h805a);
        xfer(1'b1, 1'b1, 24'h4, 16'h1111, 2'h3);
        rd(1'b0, 24'h4, 16'h0);
        xfer(1'b1, 1'b0, 24'h0, 16'h00ff, 2'h3);
        rd(1'b1, 24'h0, 16'h005a);
    endtask
    task t_lanes;
        xfer(1'b1, 1'b1, 24'h4, 16'ha55a, 2'h3);
        rd(1'b0, 24'h600004, 16'ha55a);
        xfer(1'b1, 1'b0, 24'h4, 16'hff11, 2'h1);
        rd(1'b1, 24'h4, 16'ha511);
        xfer(1'b1, 1'b1, 24'h80001e, 16'h1234, 2'h3);
        rd(1'b0, 24'he0001e, 16'h1234);
    endtask
    task t_straps;
        `CHK("port_en", 1'b1, pen)
        `CHK("hold_oe", 1'b1, i_csp_if.hold_off_oe_n)
        `CHK("pin12_oe", 1'b1, p12oe)
        xfer(1'b1, 1'b1, 24'h2, 16'h0003, 2'h1);
        `CHK("pin12_oe", 1'b0, p12oe)
        `CHK("pin12_out", 1'b1, p12out)
        rst_go(4'h0, 1'b0, 1'b0, 1'b0);
        `CHK("port_en", 1'b0, pen)
        rst_go(4'h8, 1'b1, 1'b1, 1'b1);
        `CHK("hold_oe", 1'b0, i_csp_if.hold_off_oe_n)
        `CHK("pin12_oe", 1'b0, p12oe)
        `CHK("pin12_out", 1'b0, p12out)
        rd(1'b1, 24'h0, 16'h805a);
        xfer(1'b1, 1'b0, 24'h0, 16'h0100, 2'h2);
        `CHK("pin12_out", 1'b1, p12out)
    endtask
    // Main sequence.
    initial begin
        rst_go(4'h8, 1'b0, 1'b0, 1'b0);
        t_lock;
        t_lanes;
        t_straps;
        end_sim;
    end
endmodule // card_slot_host_bus_port_test
